// >>> src/tbgp_pkg.sv
package tbgp_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned TBGP_PINS = 3;
  localparam int unsigned TBGP_REG_W = 8;
  localparam int unsigned TBGP_ADR_W = 18;
  localparam int unsigned TBGP_IDX_W = 16;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [15:0] TBGP_IDX_DATA = 16'hffd5;
  localparam logic [15:0] TBGP_IDX_DIR = 16'hffe5;
  localparam logic [15:0] TBGP_IDX_SERCTL = 16'hffda;
  localparam logic [15:0] TBGP_IDX_MODE = 16'hfff7;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned TBGP_TXD_PIN = 2;
  localparam int unsigned TBGP_MODE_TXD_BIT = 0;
  localparam logic [2:0] TBGP_DATA_RST = 3'h0;
  localparam logic [2:0] TBGP_DIR_RST = 3'h0;
  localparam logic [2:0] TBGP_SERCTL_RST = 3'h0;
  localparam logic TBGP_MODE_TXD_RST = 1'b0;
  localparam logic [7:0] TBGP_DIR_READ = 8'hff;
endpackage

// >>> src/tbgp_port.sv
// Local design decision: the Wishbone interface to the registers.
module tbgp_port
  import tbgp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [TBGP_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [TBGP_PINS-1:0] pin_i,
  output logic [TBGP_PINS-1:0] pin_o,
  output logic [TBGP_PINS-1:0] pin_oe_o,
  input wire logic [TBGP_PINS-1:0] serial_out_i,
  input wire logic [TBGP_PINS-1:0] serial_oe_i,
  input wire logic serial_txd_i
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic tbgp_hit(input logic [TBGP_ADR_W-1:0] adr,
                                    input logic [15:0] idx);
    tbgp_hit = (adr[TBGP_ADR_W-1:2] == idx);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [2:0] data_reg;
  logic [2:0] dir_reg;
  logic [2:0] serctl_reg;
  logic txd_sel_reg;
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [2:0] pin_out_reg;
  logic [2:0] pin_oe_reg;
  logic data_rd_reg;
  logic dir_rd_reg;
  wire [2:0] pin_out_next;
  wire [2:0] pin_oe_next;

  // bus decode
  wire req = wb_cyc_i && wb_stb_i;
  wire take = req && !ack_reg;
  wire commit = req && ack_reg && wb_we_i && wb_sel_i[0];
  wire hit_data = tbgp_hit(wb_adr_i, TBGP_IDX_DATA);
  wire hit_dir = tbgp_hit(wb_adr_i, TBGP_IDX_DIR);
  wire hit_serctl = tbgp_hit(wb_adr_i, TBGP_IDX_SERCTL);
  wire hit_mode = tbgp_hit(wb_adr_i, TBGP_IDX_MODE);

  // read mux: per pin, latched data or synchronised pin level
  wire [2:0] read_mux = (dir_reg & data_reg) | (~dir_reg & pin_sync_reg);
  wire [7:0] data_read = {5'h00, read_mux};
  wire [7:0] mode_read = {7'h00, txd_sel_reg};
  wire [7:0] rd_byte = hit_data ? data_read :
                       hit_dir ? TBGP_DIR_READ :
                       hit_serctl ? {5'h00, serctl_reg} :
                       hit_mode ? mode_read : 8'h00;

  // pins owned by the port logic itself
  wire [2:0] txd_mask = {txd_sel_reg && !serctl_reg[TBGP_TXD_PIN], 2'b00};
  wire [2:0] gpio_mask = ~serctl_reg & ~txd_mask;

  // ---------------------------------------------------------------
  // pin input synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else if (ce_i) begin
      pin_meta_reg <= pin_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // wishbone answer: ack one cycle after request, data with it
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
      data_rd_reg <= 1'b0;
      dir_rd_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= take;
      rdat_reg <= take && !wb_we_i ? {24'h0, rd_byte} : 32'h0;
      data_rd_reg <= take && !wb_we_i && hit_data;
      dir_rd_reg <= take && !wb_we_i && hit_dir;
    end
  end

  // ---------------------------------------------------------------
  // registers: writes land on the edge that samples ack
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_reg <= TBGP_DATA_RST;
      dir_reg <= TBGP_DIR_RST;
      serctl_reg <= TBGP_SERCTL_RST;
      txd_sel_reg <= TBGP_MODE_TXD_RST;
    end else if (ce_i && commit) begin
      if (hit_data) data_reg <= wb_dat_i[2:0];
      if (hit_dir) dir_reg <= wb_dat_i[2:0];
      if (hit_serctl) serctl_reg <= wb_dat_i[2:0];
      if (hit_mode) txd_sel_reg <= wb_dat_i[TBGP_MODE_TXD_BIT];
    end
  end

  // ---------------------------------------------------------------
  // per-pin function select
  // ---------------------------------------------------------------
  // per-pin next values: serial ownership first, then transmit, then gpio
  for (genvar n = 0; n < TBGP_PINS; n++) begin : g_pin
    wire owned = serctl_reg[n];
    wire txd_on = txd_mask[n];
    assign pin_out_next[n] = owned ? serial_out_i[n] : txd_on ? serial_txd_i : data_reg[n];
    assign pin_oe_next[n] = owned ? serial_oe_i[n] : txd_on ? 1'b1 : dir_reg[n];
  end

  // pin output flops, one process so each bit has a single driver
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_reg <= 3'h0;
      pin_oe_reg <= 3'h0;
    end else if (ce_i) begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign pin_o = pin_out_reg;
  assign pin_oe_o = pin_oe_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_data_reset;
    @(posedge clk_i) disable iff (1'b0) rst_i |=> data_reg == 3'h0;
  endproperty
  a_data_reset: assert property (p_data_reset) else $error("data not cleared");

  property p_dir_reset;
    @(posedge clk_i) disable iff (1'b0) rst_i |=> (dir_reg == 3'h0) && (pin_oe_o == 3'h0);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared");

  property p_reserved_zero;
    (wb_ack_o && data_rd_reg) |-> wb_dat_o[31:3] == 29'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_read_latched;
    (wb_ack_o && data_rd_reg && $past(ce_i)) |->
      ((wb_dat_o[2:0] ^ $past(data_reg)) & $past(dir_reg)) == 3'h0;
  endproperty
  a_read_latched: assert property (p_read_latched) else $error("output pin read wrong");

  property p_read_pin;
    (wb_ack_o && data_rd_reg && $past(ce_i)) |->
      ((wb_dat_o[2:0] ^ $past(pin_sync_reg)) & ~$past(dir_reg)) == 3'h0;
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("input pin read wrong");

  property p_dir_read;
    (wb_ack_o && dir_rd_reg) |-> wb_dat_o == 32'h0000_00ff;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read not ones");

  property p_gpio_drive;
    $past(ce_i && !rst_i) |-> (((pin_oe_o ^ $past(dir_reg)) | (pin_o ^ $past(data_reg)))
                     & $past(gpio_mask)) == 3'h0;
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("gpio pin drive wrong");

  property p_serial_own;
    $past(ce_i && !rst_i) |-> (((pin_o ^ $past(serial_out_i)) | (pin_oe_o ^ $past(serial_oe_i)))
                     & $past(serctl_reg)) == 3'h0;
  endproperty
  a_serial_own: assert property (p_serial_own) else $error("serial pin drive wrong");

  property p_txd_pin;
    $past(ce_i && !rst_i && txd_sel_reg && !serctl_reg[2]) |->
      pin_oe_o[2] && (pin_o[2] == $past(serial_txd_i));
  endproperty
  a_txd_pin: assert property (p_txd_pin) else $error("transmit pin wrong");

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o || !$past(ce_i);
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  // ---------------------------------------------------------------
  // bus timing checks
  // ---------------------------------------------------------------
  // a taken request is answered on the very next cycle
  property p_ack_after_take;
    (ce_i && take) |=> wb_ack_o;
  endproperty
  a_ack_after_take: assert property (p_ack_after_take) else $error("ack late");

  // read data stays zero outside the ack cycle
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

  // only the low byte ever carries data
  property p_dat_high_zero;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
  endproperty
  a_dat_high_zero: assert property (p_dat_high_zero) else $error("high read byte set");

  // ---------------------------------------------------------------
  // register write checks
  // ---------------------------------------------------------------
  // a committed data write lands in the low three bits
  property p_data_write;
    (ce_i && commit && hit_data) |=> data_reg == $past(wb_dat_i[2:0]);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write lost");

  // a committed direction write lands in the low three bits
  property p_dir_write;
    (ce_i && commit && hit_dir) |=> dir_reg == $past(wb_dat_i[2:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("dir write lost");

  // serial ownership bits follow their write
  property p_serctl_write;
    (ce_i && commit && hit_serctl) |=> serctl_reg == $past(wb_dat_i[2:0]);
  endproperty
  a_serctl_write: assert property (p_serctl_write) else $error("owner lost");

  // transmit select follows its write
  property p_mode_write;
    (ce_i && commit && hit_mode) |=> txd_sel_reg == $past(wb_dat_i[TBGP_MODE_TXD_BIT]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("select lost");

  // a write without the low byte lane leaves data and direction unchanged
  property p_sel_guard;
    (ce_i && req && ack_reg && wb_we_i && !wb_sel_i[0]) |=>
      $stable(data_reg) && $stable(dir_reg);
  endproperty
  a_sel_guard: assert property (p_sel_guard) else $error("masked write landed");

  // without a commit no register moves
  property p_regs_hold;
    !(ce_i && commit) |=> $stable(data_reg) && $stable(dir_reg) && $stable(serctl_reg)
      && $stable(txd_sel_reg);
  endproperty
  a_regs_hold: assert property (p_regs_hold) else $error("register moved without write");

  // ---------------------------------------------------------------
  // pin path checks
  // ---------------------------------------------------------------
  // second synchroniser stage only ever copies the first
  property p_sync_path;
    ce_i |=> pin_sync_reg == $past(pin_meta_reg);
  endproperty
  a_sync_path: assert property (p_sync_path) else $error("sync skipped");

  // with select and serial ownership clear the high pin follows its direction bit
  property p_high_gpio;
    $past(ce_i && !rst_i && !txd_sel_reg && !serctl_reg[2]) |->
      pin_oe_o[2] == $past(dir_reg[2]);
  endproperty
  a_high_gpio: assert property (p_high_gpio) else $error("high pin wrong");

  // a low clock enable freezes pins and bus answer
  property p_ce_freeze;
    !ce_i |=> $stable(pin_o) && $stable(pin_oe_o) && $stable(wb_ack_o) && $stable(wb_dat_o);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");

  // ---------------------------------------------------------------
  // scenario covers
  // ---------------------------------------------------------------
  c_data_read: cover property (wb_ack_o && data_rd_reg && dir_reg == 3'h5);
  c_dir_write: cover property (commit && hit_dir && ce_i);
  c_txd_on: cover property (txd_sel_reg && pin_oe_o[2] && !dir_reg[2]);
  c_serial_own: cover property (serctl_reg != 3'h0 && gpio_mask != 3'h0);

endmodule

// >>> sim/tbgp_pins.sv
module tbgp_pins (
  input wire logic [2:0] drv_i,
  input wire logic [2:0] oe_i,
  input wire logic [2:0] board_i,
  output logic [2:0] level_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // board level wins only where the device lets the pin float
  assign level_o = (oe_i & drv_i) | (~oe_i & board_i);
endmodule

// >>> sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tbgp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [17:0] adr = 18'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [2:0] pin_i, pin_o, pin_oe_o;
  logic [2:0] board = 3'h0;
  logic [2:0] ser_out = 3'h0;
  logic [2:0] ser_oe = 3'h0;
  logic txd = 1'b0;
  logic ce = 1'b1;
  logic [3:0] sel = 4'hf;
  logic [3:0] lane = 4'hf;
  logic [31:0] rd;
  int err_total = 0;
  int comparisons = 0;
  always #2 clk_i = ~clk_i;
  tbgp_port u_tbgp_port (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .serial_out_i(ser_out), .serial_oe_i(ser_oe), .serial_txd_i(txd));
  tbgp_pins u_tbgp_pins (.drv_i(pin_o), .oe_i(pin_oe_o), .board_i(board), .level_o(pin_i));
  // ---------------------------------------------------------------
  // bus cycle and compare
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lane;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    // hold the request until ack is seen; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("oe reset", 32'h0, {29'h0, pin_oe_o});
    bus(1'b0, TBGP_IDX_DATA, 8'h00);
    chk("pins idle", 32'h0, rd);
    bus(1'b0, TBGP_IDX_DIR, 8'h00);
    chk("dir read", 32'hff, rd);
    board <= 3'h5;
    bus(1'b1, TBGP_IDX_DATA, 8'hff);
    repeat (3) @(posedge clk_i);
    bus(1'b0, TBGP_IDX_DATA, 8'h00);
    chk("input read", 32'h5, rd);
    board <= 3'h0;
    bus(1'b1, TBGP_IDX_DIR, 8'h03);
    repeat (3) @(posedge clk_i);
    chk("oe", 32'h3, {29'h0, pin_oe_o});
    chk("out", 32'h3, {29'h0, pin_o & 3'h3});
    bus(1'b0, TBGP_IDX_DATA, 8'h00);
    chk("latched read", 32'h3, rd);
    // a write without the low byte lane must leave the data alone
    lane = 4'he;
    bus(1'b1, TBGP_IDX_DATA, 8'h00);
    lane = 4'hf;
    bus(1'b0, TBGP_IDX_DATA, 8'h00);
    chk("masked write", 32'h3, rd);
    ser_out <= 3'h4;
    ser_oe <= 3'h4;
    bus(1'b1, TBGP_IDX_SERCTL, 8'h05);
    repeat (2) @(posedge clk_i);
    chk("serial owns", 32'h6, {29'h0, pin_oe_o});
    chk("serial out", 32'h6, {29'h0, pin_o});
    bus(1'b1, TBGP_IDX_SERCTL, 8'h00);
    bus(1'b1, TBGP_IDX_MODE, 8'h01);
    repeat (2) @(posedge clk_i);
    chk("txd oe", 32'h7, {29'h0, pin_oe_o});
    chk("txd low", 32'h0, {31'h0, pin_o[2]});
    txd <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("txd high", 32'h1, {31'h0, pin_o[2]});
    // enable low freezes the pin outputs
    ce <= 1'b0;
    txd <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("frozen", 32'h1, {31'h0, pin_o[2]});
    ce <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("thawed", 32'h0, {31'h0, pin_o[2]});
    bus(1'b1, TBGP_IDX_MODE, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("txd off oe", 32'h3, {29'h0, pin_oe_o});
    // second reset in mid-run clears data and direction again
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("oe mid reset", 32'h0, {29'h0, pin_oe_o});
    bus(1'b1, TBGP_IDX_DIR, 8'h07);
    bus(1'b0, TBGP_IDX_DATA, 8'h00);
    chk("data mid reset", 32'h0, rd);
    bus(1'b0, 16'h0100, 8'h00);
    chk("unmapped", 32'h0, rd);
    end_of_test;
  end
  // watchdog against a hung bus
  initial begin
    #20000;
    err_total++;
    end_of_test;
  end
endmodule
